// File: rtl/fbp_cfg.svh
// Constants for the flash block protection logic
// Assumes a byte-addressed 64 KB array, 32-bit words
`ifndef FBP_CFG_SVH
`define FBP_CFG_SVH
`define FBP_FLASH_BYTES   32'h0001_0000
`define FBP_ADDR_W        16
`define FBP_WORD_BITS     32
`define FBP_WORD_LSB      2
`define FBP_BLOCK_LSB     10
`define FBP_REGION_LSB    11
`define FBP_BLOCK_COUNT   64
`define FBP_REGION_COUNT  32
`define FBP_BLOCK_WORDS   256
`define FBP_ERASED_WORD   32'hFFFF_FFFF
`define FBP_MODE_W        2
`endif

// File: rtl/fbp_pkg.sv
// Types for the flash block protection logic
// Assumes fbp_cfg.svh is on the include path
package fbp_pkg;
    // Protection mode of one 2 KB region
    typedef enum logic [1:0] {
        FBP_OPEN,
        FBP_READ_ONLY,
        FBP_EXEC_ONLY,
        FBP_SPARE
    } fbp_mode_t;

    // Who issues a read
    typedef enum logic [1:0] {
        FBP_SRC_FETCH,
        FBP_SRC_DATA,
        FBP_SRC_DEBUG
    } fbp_src_t;
endpackage

// File: rtl/fbp_array.sv
// Flash storage array, one word per address, erase sets one word per erase step
// Assumes callers have already checked protection
`timescale 1ns/1ps
`include "fbp_cfg.svh"
module fbp_array #(
    parameter int WORDS = `FBP_FLASH_BYTES / 4,
    parameter int AW    = 14,
    parameter int BW    = 8
) (
    input  wire logic                      clock_in,
    input  wire logic                      ce_in,
    input  wire logic                      rd_en_in,
    input  wire logic [AW-1:0]             rd_addr_in,
    output logic      [`FBP_WORD_BITS-1:0] rd_data_out,
    input  wire logic                      wr_en_in,
    input  wire logic [AW-1:0]             wr_addr_in,
    input  wire logic [`FBP_WORD_BITS-1:0] wr_data_in,
    input  wire logic                      erase_step_in,
    input  wire logic [AW-1:0]             erase_addr_in
);
    logic [`FBP_WORD_BITS-1:0] mem [WORDS];

    // Registered read, zero when refused; program clears bits, erase sets ones
    always_ff @(posedge clock_in) begin
        if (ce_in) begin
            rd_data_out <= rd_en_in ? mem[rd_addr_in] : '0;
            if (erase_step_in) begin
                mem[erase_addr_in] <= `FBP_ERASED_WORD;
            end else if (wr_en_in) begin
                mem[wr_addr_in] <= mem[wr_addr_in] & wr_data_in;
            end
        end
    end
endmodule // fbp_array

// File: rtl/fbp_top.sv
// Flash block protection: access gate in front of a 64 KB flash array
// Assumes requesters on clock_in, one request at a time per port
`timescale 1ns/1ps
`include "fbp_cfg.svh"

////////////////////////////////////////////////////////////////////////////
// How it works
// - 64 KB flash, each 1 KB block erasable
// - Erased block reads back all ones
// - One mode covers each 2 KB pair
// - Region modes: open, read-only, execute-only
// - Read-only refuses erase/program, allows reads
// - Execute-only refuses writes, fetch reads only
// - Execute-only blocks data and debugger reads
// - Permitted reads answer next cycle, no waits
module fbp_top #(
    parameter int AW = `FBP_ADDR_W,
    parameter int NR = `FBP_REGION_COUNT
) (
    input  wire logic                      clock_in,
    input  wire logic                      rst_b_in,
    input  wire logic                      ce_in,
    // Protection settings, two bits per region, held by system control
    input  wire logic [NR*`FBP_MODE_W-1:0] region_mode_in,
    // Read request
    input  wire logic                      rd_req_in,
    input  wire logic [1:0]                rd_src_in,
    input  wire logic [AW-1:0]             rd_addr_in,
    output logic                           rd_valid_out,
    output logic                           rd_denied_out,
    output logic      [`FBP_WORD_BITS-1:0] rd_data_out,
    // Program request
    input  wire logic                      prog_req_in,
    input  wire logic [AW-1:0]             prog_addr_in,
    input  wire logic [`FBP_WORD_BITS-1:0] prog_data_in,
    // Block erase request
    input  wire logic                      erase_req_in,
    input  wire logic [AW-1:0]             erase_addr_in,
    output logic                           busy_out,
    output logic                           wr_done_out,
    output logic                           wr_denied_out
);
    localparam int WAW = AW - `FBP_WORD_LSB;
    localparam int BWW = `FBP_BLOCK_LSB - `FBP_WORD_LSB;

    typedef enum logic [1:0] {
        FBP_IDLE,
        FBP_ERASING,
        FBP_FINISH
    } fbp_state_t;

    typedef struct packed {
        fbp_state_t         state;
        logic [WAW-1:0]     ers_ptr;
        logic [BWW-1:0]     ers_cnt;
        logic               rd_valid;
        logic               rd_denied;
        logic               busy;
        logic               wr_done;
        logic               wr_denied;
    } fbp_regs_t;

    fbp_regs_t r_ff;
    fbp_regs_t nxt_r;

    logic [`FBP_WORD_BITS-1:0] arr_data;
    logic                      rd_ok;
    logic                      prog_ok;
    logic                      erase_ok;
    logic                      prog_go;
    logic                      erase_step;

    ////////////////////////////////////////////////////////////////////////
    // Mode of the region holding an address
    function automatic fbp_pkg::fbp_mode_t mode_of(input logic [AW-1:0] addr);
        logic [$clog2(NR)-1:0] idx;
        idx = addr[`FBP_REGION_LSB +: $clog2(NR)];
        return fbp_pkg::fbp_mode_t'(region_mode_in[idx*`FBP_MODE_W +: `FBP_MODE_W]);
    endfunction

    // Read permission by mode and source
    function automatic logic read_allowed(input fbp_pkg::fbp_mode_t m,
                                          input logic [1:0] src);
        case (m)
            fbp_pkg::FBP_EXEC_ONLY: return src == 2'(fbp_pkg::FBP_SRC_FETCH);
            default:                return 1'b1;
        endcase
    endfunction

    // Write permission by mode
    function automatic logic write_allowed(input fbp_pkg::fbp_mode_t m);
        return m == fbp_pkg::FBP_OPEN;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Permission checks, made before the array sees the request
    assign rd_ok    = read_allowed(mode_of(rd_addr_in), rd_src_in);
    assign prog_ok  = write_allowed(mode_of(prog_addr_in));
    assign erase_ok = write_allowed(mode_of(erase_addr_in));
    assign prog_go  = prog_req_in && prog_ok && r_ff.state == FBP_IDLE && !erase_req_in;
    assign erase_step = r_ff.state == FBP_ERASING;

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        nxt_r           = r_ff;
        nxt_r.rd_valid  = 1'b0;
        nxt_r.rd_denied = 1'b0;
        nxt_r.wr_done   = 1'b0;
        nxt_r.wr_denied = 1'b0;
        if (rd_req_in) begin
            if (rd_ok) begin
                nxt_r.rd_valid = 1'b1;
            end else begin
                nxt_r.rd_denied = 1'b1;
            end
        end
        case (r_ff.state)
            FBP_IDLE: begin
                if (erase_req_in) begin
                    if (erase_ok) begin
                        nxt_r.state   = FBP_ERASING;
                        nxt_r.busy    = 1'b1;
                        nxt_r.ers_cnt = '0;
                        nxt_r.ers_ptr = {erase_addr_in[AW-1:`FBP_BLOCK_LSB],
                                         {BWW{1'b0}}};
                    end else begin
                        nxt_r.wr_denied = 1'b1;
                    end
                end else if (prog_req_in) begin
                    if (prog_ok) begin
                        nxt_r.wr_done = 1'b1;
                    end else begin
                        nxt_r.wr_denied = 1'b1;
                    end
                end
            end
            FBP_ERASING: begin
                // One word per cycle, only within the chosen 1 KB block
                nxt_r.ers_ptr = r_ff.ers_ptr + WAW'(1);
                nxt_r.ers_cnt = r_ff.ers_cnt + BWW'(1);
                if (r_ff.ers_cnt == BWW'(`FBP_BLOCK_WORDS - 1)) begin
                    nxt_r.state = FBP_FINISH;
                end
            end
            FBP_FINISH: begin
                nxt_r.state   = FBP_IDLE;
                nxt_r.busy    = 1'b0;
                nxt_r.wr_done = 1'b1;
            end
            default: begin
                nxt_r.state = FBP_IDLE;
                nxt_r.busy  = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // State register, held while ce_in is low
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            r_ff <= '0;
        end else if (ce_in) begin
            r_ff <= nxt_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Flash array
    fbp_array #(
        .WORDS (`FBP_FLASH_BYTES / 4),
        .AW    (WAW),
        .BW    (BWW)
    ) u_array (
        .clock_in      (clock_in),
        .ce_in         (ce_in),
        .rd_en_in      (rd_req_in && rd_ok),
        .rd_addr_in    (rd_addr_in[AW-1:`FBP_WORD_LSB]),
        .rd_data_out   (arr_data),
        .wr_en_in      (prog_go),
        .wr_addr_in    (prog_addr_in[AW-1:`FBP_WORD_LSB]),
        .wr_data_in    (prog_data_in),
        .erase_step_in (erase_step),
        .erase_addr_in (r_ff.ers_ptr)
    );

    // Data only shown when the read was allowed, zeroed inside the array
    assign rd_data_out   = arr_data;
    assign rd_valid_out  = r_ff.rd_valid;
    assign rd_denied_out = r_ff.rd_denied;
    assign busy_out      = r_ff.busy;
    assign wr_done_out   = r_ff.wr_done;
    assign wr_denied_out = r_ff.wr_denied;
endmodule // fbp_top

// File: dv/fbp_top_asserts.sv
// Checker for the flash protection gate
// Assumes bind onto fbp_top, modes two bits per 2 KB region
`timescale 1ns/1ps
`include "fbp_cfg.svh"
module fbp_checker #(
    parameter int AW = `FBP_ADDR_W,
    parameter int NR = `FBP_REGION_COUNT
) (
    input wire logic clock_in, rst_b_in, ce_in, rd_req_in, prog_req_in, erase_req_in,
    input wire logic rd_valid_out, rd_denied_out, busy_out, wr_done_out, wr_denied_out,
    input wire logic [NR*2-1:0] region_mode_in,
    input wire logic [1:0]      rd_src_in,
    input wire logic [AW-1:0]   rd_addr_in, prog_addr_in, erase_addr_in,
    input wire logic [31:0]     rd_data_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_b_in || !ce_in);
    function automatic logic [1:0] md(input logic [AW-1:0] x);
        return region_mode_in[x[AW-1:11]*2 +: 2];
    endfunction
    logic ws, wo;
    // Write start and open target region
    assign ws = (prog_req_in || erase_req_in) && !busy_out;
    assign wo = md(erase_req_in ? erase_addr_in : prog_addr_in) == 2'h0;
    a_read_answer: assert property (rd_req_in |=> rd_valid_out != rd_denied_out)
        else $error("read not answered once");
    a_exec_denied: assert property (rd_req_in && md(rd_addr_in) == 2'h2 &&
        rd_src_in != 2'h0 |=> rd_denied_out && rd_data_out == 32'h0)
        else $error("protected read leaked");
    a_fetch_served: assert property (rd_req_in && rd_src_in == 2'h0 |=> rd_valid_out)
        else $error("fetch refused");
    a_read_quiet: assert property (!rd_req_in |=> !rd_valid_out && !rd_denied_out)
        else $error("read answer without request");
    a_write_refused: assert property (ws && !wo |=> wr_denied_out && !busy_out)
        else $error("protected write not refused");
    a_prog_done: assert property (ws && wo && !erase_req_in |=> wr_done_out)
        else $error("program not done");
    a_erase_time: assert property (ws && wo && erase_req_in |=>
        busy_out ##257 (wr_done_out && !busy_out))
        else $error("erase timing wrong");
    a_busy_holds: assert property ($rose(busy_out) |=> busy_out [*8])
        else $error("busy dropped early");
    // Main scenarios reached
    cover property (rd_denied_out);
    cover property (wr_denied_out);
    cover property ($fell(busy_out));
endmodule // fbp_checker
bind fbp_top fbp_checker #(.AW(AW), .NR(NR)) u_chk (.*);

// File: dv/fbp_reader.sv
// Requester model: fetch, load and debugger read paths
// Assumes go_in is changed at falling edges
`timescale 1ns/1ps
module fbp_reader (
    input  wire logic        clock_in,
    input  wire logic        go_in,
    input  wire logic [1:0]  src_in,
    input  wire logic [15:0] addr_in,
    output logic             rd_req_out = 1'b0,
    output logic [1:0]       rd_src_out = 2'h0,
    output logic [15:0]      rd_addr_out = 16'h0
);
    // One-cycle request; idle lines show the inverse
    always @(negedge clock_in) begin
        rd_req_out  <= go_in;
        rd_src_out  <= go_in ? src_in : ~rd_src_out;
        rd_addr_out <= go_in ? addr_in : ~rd_addr_out;
    end
endmodule // fbp_reader

// File: dv/fbp_top_test.sv
// Bench for fbp_top: erase, program and read per mode
// Assumes fbp_reader drives the read port
`timescale 1ns/1ps
`include "fbp_cfg.svh"
module fbp_top_test;
    logic        clock_in = 0, rst_b_in = 0, ce_in = 1, go = 0;
    logic        prog_req_in = 0, erase_req_in = 0, rd_req_in;
    logic [63:0] region_mode_in = 0;
    logic [15:0] prog_addr_in = 0, erase_addr_in = 0, adr = 0, a, rd_addr_in;
    logic [31:0] prog_data_in = 0, rd_data_out, mem [int];
    logic [1:0]  src = 0, rd_src_in;
    logic        rd_valid_out, rd_denied_out, busy_out, wr_done_out, wr_denied_out;
    int          n_fail = 0, n_tests = 0, seed = 25, k, s;
    always #20 clock_in = ~clock_in;
    fbp_reader u_rdr (.clock_in(clock_in), .go_in(go), .src_in(src), .addr_in(adr),
        .rd_req_out(rd_req_in), .rd_src_out(rd_src_in), .rd_addr_out(rd_addr_in));
    fbp_top DUT (.*);
    function automatic logic [1:0] md(input logic [15:0] x);
        return region_mode_in[x[15:11]*2 +: 2];
    endfunction
    task automatic chk(input logic [31:0] g, e);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic end_sim;
        $display("tests=%0d fails=%0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Program (e=0) or erase (e=1), check answer and model
    task automatic wr(input logic e, input logic [15:0] x, input logic [31:0] d);
        int i;
        logic den;
        den = md(x) != 2'h0;
        prog_req_in <= !e;
        erase_req_in <= e;
        prog_addr_in <= x;
        erase_addr_in <= x;
        prog_data_in <= d;
        for (i = 0; i < 300; i++) begin
            @(posedge clock_in);
            #1;
            if (i == 0) chk(wr_denied_out, den);
            if (i == 0) chk(busy_out, e && !den);
            if (i == 0) begin
                @(negedge clock_in);
                prog_req_in <= 0;
                erase_req_in <= 0;
            end
            if (wr_done_out || den) break;
        end
        if (i == 300) begin
            n_fail++;
            end_sim;
        end
        chk(i, (e && !den) ? 257 : 0);
        if (!den && e) for (int j = 0; j < 256; j++) mem[{x[15:10], j[7:0]}] = `FBP_ERASED_WORD;
        if (!den && !e && mem.exists(x[15:2])) mem[x[15:2]] &= d;
        @(negedge clock_in);
    endtask
    // One read, answer registered on the take edge, checked half a cycle later
    task automatic rd(input logic [1:0] r, input logic [15:0] x);
        logic den;
        den = md(x) == 2'h2 && r != 2'h0;
        go <= 1;
        src <= r;
        adr <= x;
        @(negedge clock_in);
        go <= 0;
        @(negedge clock_in);
        chk(rd_valid_out, !den);
        chk(rd_denied_out, den);
        if (den) chk(rd_data_out, 32'h0);
        else if (mem.exists(x[15:2])) chk(rd_data_out, mem[x[15:2]]);
        @(negedge clock_in);
    endtask
    // Regions 0..2 open, read-only, execute-only; rest random
    initial begin
        region_mode_in = {$random(seed), $random(seed)};
        region_mode_in[5:0] = 6'h24;
        repeat (4) @(negedge clock_in);
        rst_b_in = 1;
        for (k = 0; k < 6; k++) begin
            a = {k[4:0], 11'h000} | (16'($random(seed)) & 16'h03FC);
            wr(1, a, 0);
            wr(1, a ^ 16'h0400, 0);
            wr(0, a, $random(seed));
            wr(0, a ^ 16'h0400, $random(seed));
            wr(1, a, 0);
            for (s = 0; s < 3; s++) rd(s[1:0], a);
            for (s = 0; s < 3; s++) rd(s[1:0], a ^ 16'h0400);
        end
        end_sim;
    end
endmodule // fbp_top_test
